// *** hw/wmi_defines.svh ***
`ifndef WMI_DEFINES_SVH
`define WMI_DEFINES_SVH

// ****************************************************************
// Clock and timing
// ****************************************************************
`define WMI_CLK_PERIOD_NS      25
`define WMI_SHORT_FILTER_US    16
`define WMI_LONG_FILTER_US     64
`define WMI_PULSE_TIME_US      100
`define WMI_PULSE_GAP_TIME_US  100
`define WMI_SHORT_FILTER_CYC   ((`WMI_SHORT_FILTER_US * 1000) / `WMI_CLK_PERIOD_NS)
`define WMI_LONG_FILTER_CYC    ((`WMI_LONG_FILTER_US * 1000) / `WMI_CLK_PERIOD_NS)
`define WMI_PULSE_CYC          ((`WMI_PULSE_TIME_US * 1000) / `WMI_CLK_PERIOD_NS)
`define WMI_GAP_CYC            ((`WMI_PULSE_GAP_TIME_US * 1000) / `WMI_CLK_PERIOD_NS)
`define WMI_TIMER_W            13

// ****************************************************************
// Field layouts and codes
// ****************************************************************
`define WMI_NUM_PINS           3
`define WMI_NUM_GPIO           2
`define WMI_NUM_SRC            5
`define WMI_NUM_FAIL           8
`define WMI_FLT_STATIC_SHORT   2'h0
`define WMI_FLT_STATIC_LONG    2'h1
`define WMI_FLT_CYCLIC_T1      2'h2
`define WMI_FLT_CYCLIC_T2      2'h3
// Fail bits 0..4: undervoltage, watchdog, short, overtemp, failure flag
`define WMI_FAIL_NO_INT_MASK   8'h1F
`define WMI_MEAS_RESET         1'h0

`endif

// *** hw/wmi_pkg.sv ***
package wmi_pkg;

  // Device operating modes from the main state machine
  typedef enum logic [2:0] {
    WMI_MODE_INIT,
    WMI_MODE_NORMAL,
    WMI_MODE_STOP,
    WMI_MODE_SLEEP,
    WMI_MODE_RESTART,
    WMI_MODE_FAILSAFE
  } wmi_mode_t;

  // Interrupt pulse sequencer states
  typedef enum logic [1:0] {
    WMI_INT_IDLE,
    WMI_INT_PULSE,
    WMI_INT_GAP
  } wmi_int_state_t;

endpackage

// *** hw/wmi_wake_filter.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "wmi_defines.svh"

module wmi_wake_filter #(
  parameter int SHORT_CYC = `WMI_SHORT_FILTER_CYC,
  parameter int LONG_CYC  = `WMI_LONG_FILTER_CYC,
  parameter int CNT_W     = 12
) (
  input  wire logic clk_i,
  input  wire logic resetn_i,
  input  wire logic ce_i,
  input  wire logic level_i,
  input  wire logic sample_i,
  input  wire logic long_i,
  output logic      level_o,
  output logic      change_o
);

  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] limit;
  logic             differs;
  logic             accept;

  // Filter window select and acceptance test
  assign limit   = long_i ? CNT_W'(LONG_CYC - 1) : CNT_W'(SHORT_CYC - 1);
  assign differs = sample_i && (level_i != level_o);
  assign accept  = differs && (cnt >= limit);

  // Stability counter, restarted whenever a sampled input crosses back
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      cnt      <= '0;
      level_o  <= 1'b0;
      change_o <= 1'b0;
    end else if (ce_i) begin
      change_o <= accept;
      if (accept) begin
        level_o <= level_i;
        cnt     <= '0;
      end else if (differs) begin
        cnt <= cnt + CNT_W'(1);
      end else if (sample_i) begin
        cnt <= '0;
      end
    end
  end

endmodule // wmi_wake_filter
`default_nettype wire

// *** hw/wmi_top.sv ***
// Behaviour
// [R1] Host assigns the cyclic sense timer to a high-side output feeding the pin.
// [R2] After reset measurement is off, pins keep wake function, switch open.
// [R3] With measurement on, switch closes only in Normal mode.
// [R4] Measurement on turns off bias sources of pins one and two.
// [R5] Measurement on keeps bias, filter, enable settings but does not apply them.
// [R6] Measurement on freezes wake and level status of pins one and two.
// [R7] Sleep with only pins one/two as sources sets SPI fail, enters Restart; the code does so only with measurement on.
// [R8] Short filter accepts level stable for 16 us nominal.
// [R9] Long filter accepts level stable for 64 us nominal.
// [R10] Interrupt in Normal or Stop drives pin low for pulse time, then high.
// [R11] Pin stays high at least the minimum gap between pulses.
// [R12] Raising an interrupt never changes the operating mode.
// [R13] Class 0 interrupts only on stored wake events of enabled sources.
// [R14] Class 1 also interrupts on stored failures; level changes never do.
// [R15] Undervoltage, watchdog, short, overtemp, failure flags never interrupt.
// [R16] Stop command with uncleared wake status raises an interrupt.
// [R17] Pending events move into status registers at pulse falling edge.
// [R18] Stored events are held until host clears; level status is not held.
// [R19] Host should reread a status register after clearing it.
// [R20] In Init mode the pin is sampled for configuration, not driven.
// [R21] Pulse and minimum gap each last 100 us nominal.
// [R22] Filter field: 00 static short, 01 static long, 10/11 cyclic short.
// [R23] Events during a pulse or gap wait for the next pulse.
`timescale 1ns/1ps
`default_nettype none
`include "wmi_defines.svh"

module wmi_top #(
  parameter int PULSE_CYC = `WMI_PULSE_CYC,
  parameter int GAP_CYC   = `WMI_GAP_CYC
) (
  input  wire logic                        clk_i,
  input  wire logic                        resetn_i,
  input  wire logic                        ce_i,
  input  wire wmi_pkg::wmi_mode_t          mode_i,
  input  wire logic                        voltage_measure_enable_i,
  input  wire logic                        int_global_i,
  input  wire logic [5:0]                  filter_mode_bits_i,
  input  wire logic [5:0]                  pin_bias_config_i,
  input  wire logic [`WMI_NUM_PINS-1:0]    wake_source_enable_i,
  input  wire logic [`WMI_NUM_GPIO-1:0]    gpio_wake_enable_i,
  input  wire logic [`WMI_NUM_SRC-1:0]     sense_pin_i,
  input  wire logic                        timer1_on_i,
  input  wire logic                        timer2_on_i,
  input  wire logic [`WMI_NUM_FAIL-1:0]    fail_event_i,
  input  wire logic [`WMI_NUM_PINS-1:0]    pin_wake_clear_i,
  input  wire logic [`WMI_NUM_GPIO-1:0]    gpio_wake_clear_i,
  input  wire logic [`WMI_NUM_FAIL-1:0]    fail_clear_i,
  input  wire logic                        sleep_cmd_i,
  input  wire logic                        stop_cmd_i,
  input  wire logic                        int_pin_i,
  output logic                             int_n_o,
  output logic                             int_oe_o,
  output logic                             config_select_o,
  output logic                             measure_switch_o,
  output logic [5:0]                       pin_bias_drive_o,
  output logic [`WMI_NUM_PINS-1:0]         pin_wake_status_o,
  output logic [`WMI_NUM_GPIO-1:0]         gpio_wake_status_o,
  output logic [`WMI_NUM_SRC-1:0]          pin_level_status_o,
  output logic [`WMI_NUM_FAIL-1:0]         fail_status_o,
  output logic                             spi_fail_set_o,
  output logic                             restart_req_o,
  output logic                             sleep_go_o
);
  import wmi_pkg::*;

  localparam int TW = `WMI_TIMER_W;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [`WMI_NUM_SRC-1:0]  sync_a;
  logic [`WMI_NUM_SRC-1:0]  sync_b;
  logic                     int_sync_a;
  logic                     int_sync_b;
  logic                     meas_en;
  logic [`WMI_NUM_SRC-1:0]  filt_level;
  logic [`WMI_NUM_SRC-1:0]  filt_change;
  logic [`WMI_NUM_SRC-1:0]  src_sample;
  logic [`WMI_NUM_SRC-1:0]  src_long;
  logic [`WMI_NUM_SRC-1:0]  meas_gate;
  logic [`WMI_NUM_SRC-1:0]  wake_en_eff;
  logic [`WMI_NUM_SRC-1:0]  wake_evt;
  logic [`WMI_NUM_SRC-1:0]  pend_wake;
  logic [`WMI_NUM_SRC-1:0]  next_pend_wake;
  logic [`WMI_NUM_SRC-1:0]  wake_xfer;
  logic [`WMI_NUM_FAIL-1:0] pend_fail;
  logic [`WMI_NUM_FAIL-1:0] next_pend_fail;
  logic [`WMI_NUM_FAIL-1:0] fail_int_mask;
  logic [`WMI_NUM_FAIL-1:0] fail_set;
  logic                     stop_req;
  logic                     int_mode;
  logic                     int_req;
  logic                     pulse_start;
  logic                     xfer;
  logic                     only_pins12;
  logic                     timer_last;
  wmi_int_state_t           state;
  wmi_int_state_t           next_state;
  logic [TW-1:0]            timer;
  logic [TW-1:0]            next_timer;
  logic [TW-1:0]            hi_cnt;
  logic [TW-1:0]            lo_cnt;

  // Field decode of one pin's two filter bits
  function automatic logic is_cyclic(input logic [1:0] f);
    return (f == `WMI_FLT_CYCLIC_T1) || (f == `WMI_FLT_CYCLIC_T2);
  endfunction

  // ****************************************************************
  // Input synchronisers and measurement enable
  // ****************************************************************
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      sync_a     <= '0;
      sync_b     <= '0;
      int_sync_a <= 1'b0;
      int_sync_b <= 1'b0;
      meas_en    <= `WMI_MEAS_RESET; // R2
    end else if (ce_i) begin
      sync_a     <= sense_pin_i;
      sync_b     <= sync_a;
      int_sync_a <= int_pin_i;
      int_sync_b <= int_sync_a;
      meas_en    <= voltage_measure_enable_i;
    end
  end

  // ****************************************************************
  // Wake filters
  // ****************************************************************
  // Pins one and two are gated while measuring; gpio pins use static short filter
  assign meas_gate = {3'h7, {2{~meas_en}}}; // R4 R6
  generate
    for (genvar i = 0; i < `WMI_NUM_SRC; i++) begin : g_src
      if (i < `WMI_NUM_PINS) begin : g_pin
        logic [1:0] f;
        assign f = filter_mode_bits_i[2*i +: 2];
        assign src_long[i]   = (f == `WMI_FLT_STATIC_LONG); // R9 R22
        assign src_sample[i] = meas_gate[i] &&
                               (!is_cyclic(f) || (f[0] ? timer2_on_i : timer1_on_i)); // R5 R22
      end else begin : g_gpio
        assign src_long[i]   = 1'b0; // R8
        assign src_sample[i] = 1'b1;
      end
      wmi_wake_filter u_filt (
        .clk_i    (clk_i),
        .resetn_i (resetn_i),
        .ce_i     (ce_i),
        .level_i  (sync_b[i]),
        .sample_i (src_sample[i]),
        .long_i   (src_long[i]),
        .level_o  (filt_level[i]),
        .change_o (filt_change[i])
      );
    end
  endgenerate

  // ****************************************************************
  // Event sorting
  // ****************************************************************
  // Stored enables of pins one and two have no effect while measuring
  assign wake_en_eff    = {gpio_wake_enable_i, wake_source_enable_i} & meas_gate; // R5 R13
  assign wake_evt       = filt_change & wake_en_eff & meas_gate; // R6
  assign fail_int_mask  = int_global_i ? ~`WMI_FAIL_NO_INT_MASK : '0; // R14 R15
  assign int_mode       = (mode_i == WMI_MODE_NORMAL) || (mode_i == WMI_MODE_STOP);
  assign xfer           = pulse_start || !int_mode; // R17
  assign wake_xfer      = xfer ? (pend_wake & meas_gate) : '0; // R6
  assign next_pend_wake = ((pend_wake & ~{`WMI_NUM_SRC{xfer}}) | wake_evt) & meas_gate; // R23
  assign next_pend_fail = (pend_fail & ~{`WMI_NUM_FAIL{xfer}}) | (fail_event_i & fail_int_mask);
  assign fail_set       = (xfer ? pend_fail : '0) | (fail_event_i & ~fail_int_mask);
  assign int_req        = (|pend_wake) || (|pend_fail) || stop_req; // R13 R14

  // Pending events and host-visible status; a set beats a same-cycle clear
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      pend_wake          <= '0;
      pend_fail          <= '0;
      pin_wake_status_o  <= '0;
      gpio_wake_status_o <= '0;
      fail_status_o      <= '0;
    end else if (ce_i) begin
      pend_wake          <= next_pend_wake;
      pend_fail          <= next_pend_fail;
      pin_wake_status_o  <= (pin_wake_status_o & ~pin_wake_clear_i) |
                            wake_xfer[`WMI_NUM_PINS-1:0]; // R18
      gpio_wake_status_o <= (gpio_wake_status_o & ~gpio_wake_clear_i) |
                            wake_xfer[`WMI_NUM_SRC-1:`WMI_NUM_PINS]; // R18
      fail_status_o      <= (fail_status_o & ~fail_clear_i) | fail_set; // R18
    end
  end

  // Level status follows the filters, frozen for measured pins
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      pin_level_status_o <= '0;
    end else if (ce_i) begin
      pin_level_status_o <= (filt_level & meas_gate) | (pin_level_status_o & ~meas_gate); // R6
    end
  end

  // ****************************************************************
  // Measurement switch, bias and sleep check
  // ****************************************************************
  assign pin_bias_drive_o = pin_bias_config_i & {2'h3, {4{~meas_en}}}; // R4 R5
  assign only_pins12      = meas_en && (|wake_source_enable_i[1:0]) &&
                            !wake_source_enable_i[2] && !(|gpio_wake_enable_i);

  // Switch control and sleep request outcome
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      measure_switch_o <= 1'b0; // R2
      spi_fail_set_o   <= 1'b0;
      restart_req_o    <= 1'b0;
      sleep_go_o       <= 1'b0;
    end else if (ce_i) begin
      measure_switch_o <= meas_en && (mode_i == WMI_MODE_NORMAL); // R3
      spi_fail_set_o   <= sleep_cmd_i && only_pins12; // R7
      restart_req_o    <= sleep_cmd_i && only_pins12; // R7
      sleep_go_o       <= sleep_cmd_i && !only_pins12;
    end
  end

  // ****************************************************************
  // Interrupt pulse sequencer
  // ****************************************************************
  // Sequencer only flags the pin; it drives no mode request
  assign pulse_start = (state == WMI_INT_IDLE) && int_mode && int_req; // R10 R12
  assign timer_last  = (state == WMI_INT_PULSE) ? (timer >= TW'(PULSE_CYC - 1))
                                                : (timer >= TW'(GAP_CYC - 1)); // R21

  // Next state: pulse, then enforced high gap
  always_comb begin
    next_state = state;
    next_timer = timer + TW'(1);
    unique case (state)
      WMI_INT_IDLE: begin
        next_timer = '0;
        if (pulse_start) begin
          next_state = WMI_INT_PULSE; // R10
        end
      end
      WMI_INT_PULSE: begin
        if (timer_last || !int_mode) begin
          next_state = WMI_INT_GAP; // R11
          next_timer = '0;
        end
      end
      WMI_INT_GAP: begin
        if (timer_last) begin
          next_state = WMI_INT_IDLE; // R11
        end
      end
    endcase
  end

  // Sequencer registers, stop-entry request and pin drive
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      state           <= WMI_INT_IDLE;
      timer           <= '0;
      stop_req        <= 1'b0;
      int_n_o         <= 1'b1;
      int_oe_o        <= 1'b0;
      config_select_o <= 1'b0;
    end else if (ce_i) begin
      state    <= next_state;
      timer    <= next_timer;
      stop_req <= (stop_req && !pulse_start) ||
                  (stop_cmd_i && (|pin_wake_status_o || |gpio_wake_status_o)); // R16
      int_n_o  <= (next_state != WMI_INT_PULSE);
      int_oe_o <= (mode_i != WMI_MODE_INIT); // R20
      if (mode_i == WMI_MODE_INIT) begin
        config_select_o <= int_sync_b; // R20
      end
    end
  end

  // ****************************************************************
  // Checks
  // ****************************************************************
  // Helper counts of high and low time on the pin
  always_ff @(posedge clk_i) begin
    if (!resetn_i) begin
      hi_cnt <= TW'(GAP_CYC);
      lo_cnt <= '0;
    end else if (ce_i) begin
      hi_cnt <= int_n_o ? ((hi_cnt < TW'(GAP_CYC)) ? hi_cnt + TW'(1) : hi_cnt) : '0;
      lo_cnt <= int_n_o ? '0 : lo_cnt + TW'(1);
    end
  end

  sequence s_int_release;
    $rose(int_n_o) && $past(int_mode);
  endsequence

  sequence s_pulse_full;
    lo_cnt == TW'(PULSE_CYC);
  endsequence

  a_reset_meas_off: assert property (@(posedge clk_i) // R2
    !resetn_i |=> !meas_en && !measure_switch_o)
    else $error("measurement not off after reset");

  a_switch_normal_only: assert property (@(posedge clk_i) disable iff (!resetn_i) // R3
    ce_i |=> measure_switch_o == $past(meas_en && mode_i == WMI_MODE_NORMAL))
    else $error("measure switch state wrong for mode");

  a_bias_off_meas: assert property (@(posedge clk_i) disable iff (!resetn_i) // R4
    meas_en |-> pin_bias_drive_o[3:0] == 4'h0)
    else $error("bias active on measured pins");

  a_meas_no_wake: assert property (@(posedge clk_i) disable iff (!resetn_i) // R6
    ce_i && meas_en |=>
      (pin_wake_status_o[1:0] & ~$past(pin_wake_status_o[1:0])) == 2'h0)
    else $error("wake status of measured pins updated");

  a_sleep_restart: assert property (@(posedge clk_i) disable iff (!resetn_i) // R7
    ce_i && sleep_cmd_i && only_pins12 |=> spi_fail_set_o && restart_req_o && !sleep_go_o)
    else $error("sleep not refused while measuring");

  a_pulse_width: assert property (@(posedge clk_i) disable iff (!resetn_i) // R10
    s_int_release |-> s_pulse_full)
    else $error("interrupt pulse width wrong");

  a_gap_min_high: assert property (@(posedge clk_i) disable iff (!resetn_i) // R11
    $fell(int_n_o) |-> $past(hi_cnt) >= TW'(GAP_CYC))
    else $error("interrupt gap too short");

  a_status_hold: assert property (@(posedge clk_i) disable iff (!resetn_i) // R18
    ce_i |=> (fail_status_o & $past(fail_status_o & ~fail_clear_i)) ==
             $past(fail_status_o & ~fail_clear_i))
    else $error("stored status lost without clear");

  a_init_no_drive: assert property (@(posedge clk_i) disable iff (!resetn_i) // R20
    ce_i && mode_i == WMI_MODE_INIT |=> !int_oe_o)
    else $error("interrupt pin driven in init");

endmodule // wmi_top
`default_nettype wire

// *** bench/wmi_host_model.sv ***
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Host side: watches the interrupt line, clears status
// ****************************************************************
module wmi_host_model (
  input  wire logic       clk_i,
  input  wire logic       int_line_i,
  output logic [2:0]      pin_wake_clear_o,
  output logic [1:0]      gpio_wake_clear_o,
  output logic [7:0]      fail_clear_o,
  output var int          pulses_o,
  output var int          last_low_o,
  output var int          min_gap_o
);
  int   low_cnt;
  int   high_cnt;
  logic seen;

  // Idle host, no clears pending
  initial begin
    pin_wake_clear_o = '0;
    gpio_wake_clear_o = '0;
    fail_clear_o = '0;
    pulses_o = 0;
    last_low_o = 0;
    min_gap_o = 1000000;
    low_cnt = 0;
    high_cnt = 0;
    seen = 1'b0;
  end

  // Measures each low pulse and each high gap between pulses
  always @(posedge clk_i) begin
    if (int_line_i === 1'b0) begin
      if (low_cnt == 0 && seen && high_cnt < min_gap_o) begin
        min_gap_o = high_cnt;
      end
      low_cnt++;
      high_cnt = 0;
    end else begin
      if (low_cnt > 0) begin
        pulses_o++;
        last_low_o = low_cnt;
        seen = 1'b1;
      end
      low_cnt = 0;
      high_cnt++;
    end
  end

  // Clears every status bit; the caller rereads afterwards
  task automatic clear_all();
    @(posedge clk_i);
    pin_wake_clear_o <= '1;
    gpio_wake_clear_o <= '1;
    fail_clear_o <= '1;
    @(posedge clk_i);
    pin_wake_clear_o <= '0;
    gpio_wake_clear_o <= '0;
    fail_clear_o <= '0;
  endtask
endmodule // wmi_host_model

`default_nettype wire

// *** bench/wmi_top_test.sv ***
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// Self-checking bench for the wake and interrupt block
// ****************************************************************
module wmi_top_test;
  import wmi_pkg::*;
  localparam int PC = 8;
  logic clk_i, resetn_i, meas, glob, sleep_cmd, stop_cmd, cfg_level, t1, t2;
  wmi_mode_t mode;
  logic [5:0] flt, bias;
  logic [2:0] wen;
  logic [4:0] pins;
  logic [7:0] fev;
  logic [2:0] pclr;
  logic [1:0] gclr, gen;
  logic [7:0] fclr;
  logic int_n, int_oe, cfg_sel, sw, spi_fail, restart, sleep_go;
  logic [5:0] bias_drv;
  logic [2:0] pws;
  logic [1:0] gws;
  logic [4:0] lvl;
  logic [7:0] fst;
  wire  logic int_line;
  int pulses, last_low, min_gap, errors, n_compared, exp_p;
  logic [31:0] seed;

  // Pin level: the block drives it or the strap level shows
  assign int_line = int_oe ? int_n : cfg_level;

  wmi_top #(.PULSE_CYC(PC), .GAP_CYC(PC)) u_dut (
    .clk_i(clk_i), .resetn_i(resetn_i), .ce_i(1'b1), .mode_i(mode),
    .voltage_measure_enable_i(meas), .int_global_i(glob), .filter_mode_bits_i(flt),
    .pin_bias_config_i(bias), .wake_source_enable_i(wen), .gpio_wake_enable_i(gen),
    .sense_pin_i(pins), .timer1_on_i(t1), .timer2_on_i(t2), .fail_event_i(fev),
    .pin_wake_clear_i(pclr), .gpio_wake_clear_i(gclr), .fail_clear_i(fclr),
    .sleep_cmd_i(sleep_cmd), .stop_cmd_i(stop_cmd), .int_pin_i(int_line),
    .int_n_o(int_n), .int_oe_o(int_oe), .config_select_o(cfg_sel), .measure_switch_o(sw),
    .pin_bias_drive_o(bias_drv), .pin_wake_status_o(pws), .gpio_wake_status_o(gws),
    .pin_level_status_o(lvl), .fail_status_o(fst), .spi_fail_set_o(spi_fail),
    .restart_req_o(restart), .sleep_go_o(sleep_go));

  wmi_host_model u_host (
    .clk_i(clk_i), .int_line_i(int_line), .pin_wake_clear_o(pclr),
    .gpio_wake_clear_o(gclr), .fail_clear_o(fclr), .pulses_o(pulses),
    .last_low_o(last_low), .min_gap_o(min_gap));

  // Free-running clock, 25 ns period
  initial begin
    clk_i = 1'b0;
    forever #12.5 clk_i = ~clk_i;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Waits n edges, then moves to the falling edge to sample
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge clk_i);
    @(negedge clk_i);
  endtask

  task automatic sleep_try(input logic [2:0] en, input logic exp_fail);
    @(posedge clk_i);
    wen <= en;
    sleep_cmd <= 1'b1;
    @(posedge clk_i);
    sleep_cmd <= 1'b0;
    @(negedge clk_i);
    check("spi_fail", spi_fail, exp_fail);
    check("restart", restart, exp_fail);
    check("sleep_go", sleep_go, !exp_fail);
  endtask

  task automatic end_sim();
    $display("compared %0d errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Watchdog sized well above the expected run
  initial begin
    #(25 * 30000);
    errors++;
    end_sim();
  end

  // Main sequence
  initial begin
    errors = 0; n_compared = 0; exp_p = 0;
    seed = 32'h2315CA13;
    resetn_i = 1'b0; mode = WMI_MODE_INIT; meas = 1'b0; glob = 1'b0;
    sleep_cmd = 1'b0; stop_cmd = 1'b0; cfg_level = 1'b1; flt = 6'h00;
    bias = seed[5:0]; wen = 3'h7; pins = 5'h00; fev = 8'h00;
    gen = 2'h3; t1 = 1'b0; t2 = 1'b0;
    repeat (20) @(posedge clk_i);
    resetn_i <= 1'b1;
    wait_cyc(1);
    check("int_oe", int_oe, 1'b0);
    check("int_n", int_n, 1'b1);
    check("switch", sw, 1'b0);
    check("bias", bias_drv, bias);
    check("status", {pws, gws, fst}, 0);
    wait_cyc(10);
    check("cfg_sel", cfg_sel, 1'b1);
    @(posedge clk_i);
    mode <= WMI_MODE_NORMAL;
    wait_cyc(5);
    // Short filter boundaries on pin three, then pulse
    @(posedge clk_i);
    pins[2] <= 1'b1;
    wait_cyc(470);
    check("lvl_short_early", lvl, 5'h00);
    wait_cyc(340);
    exp_p++;
    check("lvl_short", lvl, 5'h04);
    check("wake_short", pws, 3'h4);
    check("pulses", pulses, exp_p);
    check("pulse_len", last_low, PC);
    // Long filter on pin one
    @(posedge clk_i);
    flt <= 6'h01;
    pins[0] <= 1'b1;
    wait_cyc(1990);
    check("lvl_long_early", lvl[0], 1'b0);
    wait_cyc(1220);
    exp_p++;
    check("lvl_long", lvl[0], 1'b1);
    check("wake_long", pws, 3'h5);
    check("pulses", pulses, exp_p);
    // Disabled pin two: level only; gpio one wakes and pulses
    @(posedge clk_i);
    wen <= 3'h5;
    pins[3:1] <= 3'h7;
    wait_cyc(900);
    exp_p++;
    check("lvl_dis", lvl, 5'h0F);
    check("wake_dis", pws, 3'h5);
    check("gpio_wake", gws, 2'h1);
    check("pulses", pulses, exp_p);
    u_host.clear_all();
    @(negedge clk_i);
    check("reread", {pws, gws}, 5'h00);
    check("lvl_kept", lvl, 5'h0F);
    // Failure class: exempt bits, then two back-to-back events
    @(posedge clk_i);
    glob <= 1'b1;
    fev <= 8'h1F;
    @(posedge clk_i);
    fev <= 8'h00;
    wait_cyc(30);
    check("fail_exempt", fst, 8'h1F);
    check("pulses", pulses, exp_p);
    @(posedge clk_i);
    fev <= 8'h20;
    @(posedge clk_i);
    fev <= 8'h00;
    repeat (2) @(posedge clk_i);
    fev <= 8'h40;
    @(posedge clk_i);
    fev <= 8'h00;
    wait_cyc(60);
    exp_p += 2;
    check("fail_int", fst, 8'h7F);
    check("pulses", pulses, exp_p);
    check("gap_min", min_gap >= PC + 1, 1);
    // Cyclic pin three on timer 1: blind while only timer 2 runs
    @(posedge clk_i);
    flt <= 6'h21;
    t2 <= 1'b1;
    pins[2] <= 1'b0;
    wait_cyc(820);
    check("cyc_off", pws, 3'h0);
    @(posedge clk_i);
    t1 <= 1'b1;
    wait_cyc(820);
    exp_p++;
    check("wake_again", pws, 3'h4);
    // Uncleared wake status on a Stop command
    @(posedge clk_i);
    mode <= WMI_MODE_STOP;
    stop_cmd <= 1'b1;
    @(posedge clk_i);
    stop_cmd <= 1'b0;
    wait_cyc(40);
    exp_p++;
    check("stop_int", pulses, exp_p);
    // Measurement path
    u_host.clear_all();
    mode <= WMI_MODE_NORMAL;
    meas <= 1'b1;
    seed = lfsr(seed);
    bias <= seed[5:0];
    wen <= 3'h7;
    gen <= 2'h0;
    wait_cyc(3);
    check("switch_on", sw, 1'b1);
    check("bias_meas", bias_drv, {bias[5:4], 4'h0});
    @(posedge clk_i);
    pins[0] <= 1'b0;
    flt <= 6'h00;
    wait_cyc(900);
    check("lvl_frozen", lvl[0], 1'b1);
    check("wake_frozen", pws, 3'h0);
    check("pulses", pulses, exp_p);
    @(posedge clk_i);
    mode <= WMI_MODE_STOP;
    wait_cyc(3);
    check("switch_off", sw, 1'b0);
    sleep_try(3'h3, 1'b1);
    sleep_try(3'h7, 1'b0);
    end_sim();
  end
endmodule // wmi_top_test

`default_nettype wire
